// file: include/ets_pkg.sv
package ets_pkg;
	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NUM_LINES        = 4;           // Input lines
	localparam int SMALL_ENTRIES    = 5;           // 20-byte image
	localparam int LARGE_ENTRIES    = 15;          // 60-byte image
	localparam int FIFO_DEPTH       = 8;           // Capture buffer depth
	localparam int ENTRY_BITS       = 32;          // One image entry

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ          = 100;         // Clock rate in MHz
	localparam int US_CYCLES        = CLK_MHZ;     // Cycles per microsecond

	// ************************************************************
	// Record sets and object indices
	// ************************************************************
	localparam logic [7:0]  REC_DIAG_HEAD  = 8'h00;   // First 4 bytes only
	localparam logic [7:0]  REC_DIAG_FULL  = 8'h01;   // Whole diagnostic record
	localparam logic [7:0]  REC_PARAM_DLY  = 8'h01;   // Filter delay codes
	localparam logic [7:0]  REC_PARAM_LEN  = 8'h02;   // Image length record
	localparam logic [7:0]  REC_PARAM_EDGE = 8'h80;   // Edge selects
	localparam logic [15:0] IDX_DIAG_HEAD  = 16'h2f00;
	localparam logic [15:0] IDX_DIAG_FULL  = 16'h2f01;
	localparam logic [15:0] IDX_IN_LEN     = 16'h3100;
	localparam logic [15:0] IDX_OUT_LEN    = 16'h3101;
	localparam logic [15:0] IDX_DLY0       = 16'h3102;
	localparam logic [15:0] IDX_RISE       = 16'h3106;
	localparam logic [15:0] IDX_FALL       = 16'h3107;
	localparam int          DIAG_BYTES     = 20;
	localparam int          DIAG_HEAD_BYTES = 4;

	// ************************************************************
	// Fixed and reset values
	// ************************************************************
	localparam logic [7:0] IN_LEN_SMALL   = 8'h14;
	localparam logic [7:0] IN_LEN_LARGE   = 8'h3c;
	localparam logic [7:0] OUT_LEN        = 8'h00;
	localparam logic [7:0] DLY_RESET      = 8'h02;
	localparam logic [7:0] EDGE_RESET     = 8'h00;
	localparam logic [3:0] EDGE_MASK      = 4'hf;    // Bits 3..0 are live
	localparam logic [7:0] MODULE_INFO    = 8'h1f;
	localparam logic [7:0] CHANNEL_KIND   = 8'h70;
	localparam logic [7:0] DIAG_BITS      = 8'h00;
	localparam logic [7:0] CHANNEL_COUNT  = 8'h04;
	localparam logic [7:0] RSVD_BYTE      = 8'h00;

	// ************************************************************
	// Filter delay codes, named by their delay in microseconds
	// ************************************************************
	localparam logic [7:0] DLY_1US    = 8'h00;
	localparam logic [7:0] DLY_3US    = 8'h02;
	localparam logic [7:0] DLY_10US   = 8'h04;
	localparam logic [7:0] DLY_86US   = 8'h07;
	localparam logic [7:0] DLY_342US  = 8'h09;
	localparam logic [7:0] DLY_2731US = 8'h0c;

	// Image entry: newest-first, state byte at +0
	typedef struct packed {
		logic [7:0]  state;     // Input states, bits 3..0
		logic [7:0]  seq;       // Running entry number
		logic [15:0] stamp;     // Low half of microsecond timer
	} entry_t;

	// Parameter / record access port
	typedef struct packed {
		logic        rd;        // Read strobe
		logic        wr;        // Write strobe
		logic        by_index;  // 1: object index, 0: record set
		logic [15:0] sel;       // Index or record set number
		logic [7:0]  offset;    // Byte within the object
		logic [7:0]  wdata;     // Write byte
	} req_t;

	typedef struct packed {
		logic       ack;        // One-cycle answer
		logic       err;        // Refused or unmapped
		logic [7:0] rdata;      // Read byte
	} rsp_t;
endpackage

// file: rtl/ets_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module ets_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];   // Storage
	logic [AW-1:0]    wr_ff;            // Write index
	logic [AW-1:0]    rd_ff;            // Read index
	logic [AW:0]      cnt_ff;           // Fill level
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	// Indices and level
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // ets_fifo
`default_nettype wire

// file: rtl/edge_timestamp_input.sv
`timescale 1ns/1ns
`default_nettype none
module edge_timestamp_input
	import ets_pkg::*;
#(
	parameter bit LARGE_IMAGE = 1'b0   // Variant chosen at build
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [3:0]   input_line,
	input  wire logic         bus_stopped,
	input  wire ets_pkg::req_t req,
	output ets_pkg::rsp_t     rsp,
	input  wire logic [5:0]   image_byte_sel,
	output logic [7:0]        image_byte,
	output logic              param_error
);
	import ets_pkg::*;

	// ************************************************************
	// Constants of the variant
	// ************************************************************
	localparam int         ENTRIES = LARGE_IMAGE ? LARGE_ENTRIES : SMALL_ENTRIES;
	localparam logic [7:0] IN_LEN  = LARGE_IMAGE ? IN_LEN_LARGE : IN_LEN_SMALL;

	// ************************************************************
	// State
	// ************************************************************
	logic [3:0]  sync1_ff;                  // First sync stage
	logic [3:0]  sync2_ff;                  // Second sync stage
	logic [3:0]  filt_ff;                   // Filtered line levels
	logic [31:0] flt_cnt_ff [NUM_LINES];    // Per-line stable time
	logic [7:0]  dly_ff [NUM_LINES];        // Filter delay codes
	logic [3:0]  rise_ff;                   // Rising edge enables
	logic [3:0]  fall_ff;                   // Falling edge enables
	logic [6:0]  us_div_ff;                 // Microsecond divider
	logic        us_tick_ff;                // One pulse per microsecond
	logic [31:0] us_ff;                     // Microsecond timer
	logic [7:0]  seq_ff;                    // Running entry number
	logic [31:0] diag_microsecond_ticker_ff;                // Latched ticker
	entry_t      img_ff [LARGE_ENTRIES];    // Newest-first image
	rsp_t        rsp_ff;
	logic [7:0]  img_byte_ff;
	logic        perr_ff;
	logic [3:0]  nxt_filt;
	logic [3:0]  edge_hit;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	entry_t      fifo_out;
	entry_t      new_entry;

	assign rsp         = rsp_ff;
	assign image_byte  = img_byte_ff;
	assign param_error = perr_ff;

	// Delay code to cycle count; 0 marks an illegal code
	function automatic logic [31:0] dly_cycles(input logic [7:0] code);
		unique case (code)
			DLY_1US:    dly_cycles = 32'(1 * US_CYCLES);
			DLY_3US:    dly_cycles = 32'(3 * US_CYCLES);
			DLY_10US:   dly_cycles = 32'(10 * US_CYCLES);
			DLY_86US:   dly_cycles = 32'(86 * US_CYCLES);
			DLY_342US:  dly_cycles = 32'(342 * US_CYCLES);
			DLY_2731US: dly_cycles = 32'(2731 * US_CYCLES);
			default:    dly_cycles = 32'h0;
		endcase
	endfunction

	// ************************************************************
	// Pin synchroniser
	// ************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
		end else begin
			sync1_ff <= input_line;
			sync2_ff <= sync1_ff;
		end
	end

	// ************************************************************
	// Microsecond timer
	// ************************************************************
	// Divider makes a one-cycle enable; the timer wraps naturally
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			us_div_ff  <= 7'h0;
			us_tick_ff <= 1'b0;
			us_ff      <= 32'h0;
		end else begin
			us_tick_ff <= (us_div_ff == 7'(US_CYCLES - 1));
			us_div_ff  <= (us_div_ff == 7'(US_CYCLES - 1)) ? 7'h0 : us_div_ff + 7'h1;
			if (us_tick_ff) begin
				us_ff <= us_ff + 32'h1;
			end
		end
	end

	// ************************************************************
	// Per-line filter and edge detect
	// ************************************************************
	// A level is accepted once it has been stable for the chosen delay
	for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				flt_cnt_ff[i] <= 32'h0;
			end else if (sync2_ff[i] == filt_ff[i]) begin
				flt_cnt_ff[i] <= 32'h0;
			end else begin
				flt_cnt_ff[i] <= flt_cnt_ff[i] + 32'h1;
			end
		end
		assign nxt_filt[i] = (sync2_ff[i] != filt_ff[i]) &&
		                     (flt_cnt_ff[i] + 32'h1 >= dly_cycles(dly_ff[i]))
		                     ? sync2_ff[i] : filt_ff[i];
		assign edge_hit[i] = (nxt_filt[i] && !filt_ff[i] && rise_ff[i]) ||
		                     (!nxt_filt[i] && filt_ff[i] && fall_ff[i]);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			filt_ff <= 4'h0;
		end else begin
			filt_ff <= nxt_filt;
		end
	end

	// ************************************************************
	// Capture into the buffer
	// ************************************************************
	// Several lines switching together give one entry; states show all
	assign new_entry = '{state: {4'h0, nxt_filt}, seq: seq_ff,
	                     stamp: us_ff[15:0]};

	// Edge lost only if the buffer is full, which cannot happen as it drains one entry every cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seq_ff <= 8'h0;
		end else if ((|edge_hit) && fifo_in_ready) begin
			seq_ff <= seq_ff + 8'h1;
		end
	end

	ets_fifo #(
		.WIDTH (ENTRY_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (|edge_hit),
		.in_ready  (fifo_in_ready),
		.in_data   (new_entry),
		.out_valid (fifo_out_valid),
		.out_ready (1'b1),
		.out_data  (fifo_out)
	);

	// ************************************************************
	// Image shift register
	// ************************************************************
	// Entries beyond the variant never get written and read zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int k = 0; k < LARGE_ENTRIES; k++) begin
				img_ff[k] <= '0;
			end
		end else if (fifo_out_valid) begin
			img_ff[0] <= fifo_out;
			for (int k = 1; k < ENTRIES; k++) begin
				img_ff[k] <= img_ff[k-1];
			end
		end
	end

	// Image byte read port, registered
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			img_byte_ff <= 8'h0;
		end else if (image_byte_sel < 6'(IN_LEN)) begin
			img_byte_ff <= img_ff[image_byte_sel[5:2]][8*(3-image_byte_sel[1:0]) +: 8];
		end else begin
			img_byte_ff <= 8'h0;
		end
	end

	// ************************************************************
	// Diagnostic record
	// ************************************************************
	function automatic logic [7:0] diag_byte(input logic [7:0] n, input logic [31:0] us);
		unique case (n)
			8'd1:    diag_byte = MODULE_INFO;
			8'd4:    diag_byte = CHANNEL_KIND;
			8'd5:    diag_byte = DIAG_BITS;
			8'd6:    diag_byte = CHANNEL_COUNT;
			8'd16:   diag_byte = us[7:0];
			8'd17:   diag_byte = us[15:8];
			8'd18:   diag_byte = us[23:16];
			8'd19:   diag_byte = us[31:24];
			default: diag_byte = RSVD_BYTE;
		endcase
	endfunction

	logic diag_hit;
	logic diag_len_ok;
	assign diag_hit = req.by_index ?
		(req.sel == IDX_DIAG_FULL || req.sel == IDX_DIAG_HEAD) :
		(req.sel[15:8] == 8'h00 &&
		(req.sel[7:0] == REC_DIAG_FULL || req.sel[7:0] == REC_DIAG_HEAD));
	assign diag_len_ok = ((req.by_index && req.sel == IDX_DIAG_FULL) ||
		(!req.by_index && req.sel[7:0] == REC_DIAG_FULL)) ?
		(req.offset < 8'(DIAG_BYTES)) : (req.offset < 8'(DIAG_HEAD_BYTES));

	// Ticker is latched when a read starts the record at byte 0
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			diag_microsecond_ticker_ff <= 32'h0;
		end else if (req.rd && diag_hit && req.offset == 8'h0) begin
			diag_microsecond_ticker_ff <= us_ff;
		end
	end

	// ************************************************************
	// Parameter access
	// ************************************************************
	// Parameter record sets share numbers with diagnostics, so record-set
	// parameter access uses sel[15:8]=01h to keep them apart
	logic       prm_rec;
	logic [7:0] prm_byte;
	logic [15:0] idx;
	assign prm_rec = !req.by_index && req.sel[15:8] == 8'h01;
	always_comb begin
		idx = 16'h0;
		if (req.by_index) begin
			idx = req.sel;
		end else if (prm_rec && req.sel[7:0] == REC_PARAM_LEN && req.offset < 8'h02) begin
			idx = IDX_IN_LEN + 16'(req.offset);
		end else if (prm_rec && req.sel[7:0] == REC_PARAM_DLY && req.offset < 8'h04) begin
			idx = IDX_DLY0 + 16'(req.offset);
		end else if (prm_rec && req.sel[7:0] == REC_PARAM_EDGE && req.offset < 8'h02) begin
			idx = IDX_RISE + 16'(req.offset);
		end
	end
	always_comb begin
		unique case (idx)
			IDX_IN_LEN:  prm_byte = IN_LEN;
			IDX_OUT_LEN: prm_byte = OUT_LEN;
			16'h3102:    prm_byte = dly_ff[0];
			16'h3103:    prm_byte = dly_ff[1];
			16'h3104:    prm_byte = dly_ff[2];
			16'h3105:    prm_byte = dly_ff[3];
			IDX_RISE:    prm_byte = {4'h0, rise_ff};
			IDX_FALL:    prm_byte = {4'h0, fall_ff};
			default:     prm_byte = 8'h0;
		endcase
	end

	logic prm_mapped;
	assign prm_mapped = (idx >= IDX_IN_LEN) && (idx <= IDX_FALL);

	// Register writes; the length bytes are read-only and a write to them is
	// refused in every state, stopped or not
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int k = 0; k < NUM_LINES; k++) begin
				dly_ff[k] <= DLY_RESET;
			end
			rise_ff <= EDGE_RESET[3:0];
			fall_ff <= EDGE_RESET[3:0];
			perr_ff <= 1'b0;
		end else if (req.wr && !diag_hit) begin
			if (idx >= IDX_DLY0 && idx < IDX_RISE) begin
				if (dly_cycles(req.wdata) != 32'h0) begin
					dly_ff[idx[1:0] - 2'd2] <= req.wdata;
					perr_ff <= 1'b0;
				end else begin
					perr_ff <= 1'b1;
				end
			end else if (idx == IDX_RISE) begin
				rise_ff <= req.wdata[3:0] & EDGE_MASK;
			end else if (idx == IDX_FALL) begin
				fall_ff <= req.wdata[3:0] & EDGE_MASK;
			end
		end
	end

	// Answer path: one-cycle ack with data or error
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.ack <= req.rd || req.wr;
			if (req.rd && diag_hit) begin
				rsp_ff.rdata <= diag_byte(req.offset,
					(req.offset == 8'h0) ? us_ff : diag_microsecond_ticker_ff);
				rsp_ff.err   <= !diag_len_ok;
			end else if (req.rd) begin
				rsp_ff.rdata <= prm_byte;
				rsp_ff.err   <= !prm_mapped;
			end else if (req.wr) begin
				rsp_ff.rdata <= 8'h0;
				rsp_ff.err   <= diag_hit || !prm_mapped || idx <= IDX_OUT_LEN ||
					(idx >= IDX_DLY0 && idx < IDX_RISE && dly_cycles(req.wdata) == 32'h0) ||
					(prm_rec && req.sel[7:0] == REC_PARAM_LEN && !bus_stopped);
			end else begin
				rsp_ff.rdata <= 8'h0;
				rsp_ff.err   <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	chk_timer_step: assert property (@(posedge clk) disable iff (!reset_n)
		us_tick_ff |=> us_ff == $past(us_ff) + 32'h1)
		else $error("timer did not step");
	chk_timer_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!us_tick_ff |=> $stable(us_ff))
		else $error("timer moved without tick");
	chk_image_shift: assert property (@(posedge clk) disable iff (!reset_n)
		fifo_out_valid |=> img_ff[1] == $past(img_ff[0]))
		else $error("image did not shift");
	chk_image_newest: assert property (@(posedge clk) disable iff (!reset_n)
		fifo_out_valid |=> img_ff[0] == $past(fifo_out))
		else $error("newest entry not at front");
	chk_image_tail: assert property (@(posedge clk) disable iff (!reset_n)
		img_ff[LARGE_ENTRIES-1] == '0 || ENTRIES == LARGE_ENTRIES)
		else $error("entry beyond variant");
	chk_edge_disabled: assert property (@(posedge clk) disable iff (!reset_n)
		(rise_ff == 4'h0 && fall_ff == 4'h0) |-> !(|edge_hit))
		else $error("edge recorded while disabled");
	chk_bad_code: assert property (@(posedge clk) disable iff (!reset_n)
		(req.wr && !diag_hit && idx == IDX_DLY0 && dly_cycles(req.wdata) == 32'h0)
		|=> perr_ff && dly_ff[0] == $past(dly_ff[0]))
		else $error("bad delay code accepted");
	chk_len_fixed: assert property (@(posedge clk) disable iff (!reset_n)
		(req.rd && !diag_hit && idx == IDX_IN_LEN) |=> rsp.rdata == IN_LEN)
		else $error("length reads wrong");
endmodule // edge_timestamp_input
`default_nettype wire

// file: verif/ets_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************
// Controller side of the record port
// ************************************
module ets_host_model (
	input  wire logic          clk,
	output var ets_pkg::req_t  req,
	input  wire ets_pkg::rsp_t rsp,
	output var logic           bus_stopped
);
	import ets_pkg::*;
	// Idle port; start stopped, where a length write is still refused
	initial begin
		req = '0;
		bus_stopped = 1'b1;
	end
	// Enter or leave the stopped state between accesses
	task automatic set_stopped(input logic s);
		@(posedge clk);
		bus_stopped <= s;
	endtask
	// One access: strobe for one edge only, since a held strobe is taken twice
	task automatic xfer(input logic wr, input logic [15:0] sel,
		input logic [7:0] off, input logic [7:0] wd,
		output logic [7:0] rd, output logic err, output logic ok);
		ok = 1'b0;
		rd = 8'h00;
		err = 1'b1;
		@(posedge clk);
		req <= '{rd: !wr, wr: wr, by_index: (sel[15:12] != 4'h0),
			sel: sel, offset: off, wdata: wd};
		@(posedge clk);
		req.rd <= 1'b0;
		req.wr <= 1'b0;
		// Bounded wait; the answer is due at the first edge
		for (int n = 0; n < 4 && !ok; n++) begin
			@(posedge clk);
			if (rsp.ack) begin
				rd = rsp.rdata;
				err = rsp.err;
				ok = 1'b1;
			end
		end
	endtask
endmodule // ets_host_model
`default_nettype wire

// file: verif/tb_edge_timestamp_input.sv
`timescale 1ns/1ns
`default_nettype none
module tb_edge_timestamp_input;
	import ets_pkg::*;
	logic          clk;
	logic          reset_n;
	logic [3:0]    input_line;
	logic          bus_stopped;
	req_t          req;
	rsp_t          rsp;
	logic [5:0]    image_byte_sel;
	logic [7:0]    image_byte;
	logic          param_error;
	int            bad_count;
	int            tests_run;
	logic [7:0]    hist[$];     // Expected entry states, newest first
	logic [31:0]   tick[2];     // Two latched ticker values
	logic [7:0]    codes[6] = '{DLY_2731US, DLY_342US, DLY_86US, DLY_10US, DLY_3US, DLY_1US};
	logic [3:0]    pat[11] = '{4'h1, 4'h0, 4'h2, 4'h0, 4'h1, 4'h3, 4'h1, 4'h0, 4'h2, 4'h0,
	                           4'h1};

	edge_timestamp_input #(.LARGE_IMAGE(1'b0)) i_dut (.clk(clk), .reset_n(reset_n),
		.input_line(input_line), .bus_stopped(bus_stopped), .req(req), .rsp(rsp),
		.image_byte_sel(image_byte_sel), .image_byte(image_byte),
		.param_error(param_error));
	ets_host_model i_host (.clk(clk), .req(req), .rsp(rsp), .bus_stopped(bus_stopped));

	// ********************************
	// Clock and helpers
	// ********************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Counts, verdict, end of run
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// One access; a missing answer ends the run
	task automatic acc(input logic wr, input logic [15:0] sel, input logic [7:0] off,
		input logic [7:0] wd, output logic [7:0] rd, output logic err);
		logic ok;
		i_host.xfer(wr, sel, off, wd, rd, err, ok);
		if (!ok) begin
			bad_count++;
			final_report();
		end
	endtask
	// Read; data only matters when not refused
	task automatic rchk(input logic [15:0] s, input logic [7:0] o, input logic [7:0] x,
		input logic xe);
		logic [7:0] rd;
		logic err;
		acc(1'b0, s, o, 8'h00, rd, err);
		chk({err, xe ? 8'h00 : rd}, {xe, x});
	endtask
	task automatic wchk(input logic [15:0] s, input logic [7:0] o, input logic [7:0] wd,
		input logic xe);
		logic [7:0] rd;
		logic err;
		acc(1'b1, s, o, wd, rd, err);
		chk(err, xe);
	endtask
	// Image byte: registered one cycle after the select
	task automatic img(input int a, output logic [7:0] v);
		@(posedge clk);
		image_byte_sel <= a[5:0];
		repeat (2) @(posedge clk);
		v = image_byte;
	endtask
	// Fixed diagnostic bytes below the ticker
	function automatic logic [7:0] dexp(input int o);
		case (o)
			1: return MODULE_INFO;
			4: return CHANNEL_KIND;
			5: return DIAG_BITS;
			6: return CHANNEL_COUNT;
			default: return RSVD_BYTE;
		endcase
	endfunction
	// Drive lines, let the 1 us filter settle, compare the whole image
	task automatic step(input logic [3:0] v);
		logic [7:0] b;
		logic [15:0] st;
		logic [15:0] newer;
		if ((v & ~input_line & 4'h1) != 0 || (~v & input_line & 4'h2) != 0)
			hist.push_front({4'h0, v});
		@(posedge clk);
		input_line <= v;
		repeat (140) @(posedge clk);
		for (int k = 0; k < SMALL_ENTRIES; k++)
			for (int j = 0; j < 4; j++) begin
				img(4 * k + j, b);
				if (k >= hist.size()) chk(b, 8'h00);
				else if (j == 0) chk(b, hist[k]);
				else if (j == 1) chk(b, 8'(hist.size() - 1 - k));
				else if (j == 2) st[15:8] = b;
				else begin
					st[7:0] = b;
					if (k > 0) chk(newer > st, 1);
					newer = st;
				end
			end
		img(20, b);
		chk(b, 8'h00);
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		logic [7:0] b;
		logic e;
		reset_n = 1'b0;
		input_line = 4'h0;
		image_byte_sel = 6'h00;
		bad_count = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		// Reset values and fixed lengths
		rchk(IDX_IN_LEN, 0, IN_LEN_SMALL, 0);
		rchk(IDX_OUT_LEN, 0, OUT_LEN, 0);
		for (int i = 0; i < 4; i++) rchk(16'(IDX_DLY0 + i), 0, DLY_RESET, 0);
		rchk(IDX_RISE, 0, EDGE_RESET, 0);
		rchk(IDX_FALL, 0, EDGE_RESET, 0);
		wchk(IDX_IN_LEN, 0, IN_LEN_LARGE, 1);
		rchk({8'h01, REC_PARAM_LEN}, 0, IN_LEN_SMALL, 0);
		wchk(IDX_OUT_LEN, 0, 8'h05, 1);
		rchk({8'h01, REC_PARAM_LEN}, 1, OUT_LEN, 0);
		i_host.set_stopped(1'b0);
		wchk({8'h01, REC_PARAM_LEN}, 0, IN_LEN_SMALL, 1);
		// Illegal delay code refused, old value kept
		wchk(IDX_DLY0, 0, 8'h05, 1);
		chk(param_error, 1'b1);
		rchk(IDX_DLY0, 0, DLY_RESET, 0);
		for (int i = 0; i < 6; i++) begin
			wchk(IDX_DLY0, 0, codes[i], 0);
			rchk({8'h01, REC_PARAM_DLY}, 0, codes[i], 0);
		end
		chk(param_error, 1'b0);
		wchk(16'(IDX_DLY0 + 1), 0, DLY_1US, 0);
		// Rising on line 0, falling on line 1
		wchk(IDX_RISE, 0, 8'h01, 0);
		wchk({8'h01, REC_PARAM_EDGE}, 1, 8'h02, 0);
		rchk(IDX_FALL, 0, 8'h02, 0);
		foreach (pat[i]) step(pat[i]);
		// Diagnostic record twice, about 10 us apart
		for (int r = 0; r < 2; r++) begin
			for (int o = 0; o < DIAG_BYTES; o++) begin
				acc(1'b0, IDX_DIAG_FULL, o[7:0], 8'h00, b, e);
				if (o < 16) chk({e, b}, {1'b0, dexp(o)});
				else tick[r][8 * (o - 16) +: 8] = b;
			end
			repeat (1000) @(posedge clk);
		end
		chk((tick[1] - tick[0] - 32'd9) < 32'd5, 1);
		rchk(IDX_DIAG_FULL, 20, 8'h00, 1);
		rchk(IDX_DIAG_HEAD, 1, MODULE_INFO, 0);
		rchk(IDX_DIAG_HEAD, 4, 8'h00, 1);
		rchk({8'h00, REC_DIAG_FULL}, 6, CHANNEL_COUNT, 0);
		rchk({8'h00, REC_DIAG_HEAD}, 4, 8'h00, 1);
		wchk(IDX_DIAG_FULL, 1, 8'h00, 1);
		rchk(16'h1234, 0, 8'h00, 1);
		final_report();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		final_report();
	end
endmodule // tb_edge_timestamp_input
`default_nettype wire
